// ---- hdl/rail_limit_monitor.sv ----
// Rail limit monitor: margin-low target, scaling, limit checks with hysteresis, status and alert
`timescale 1ns/10ps
// Behaviour
// - Margin-low command drives stored low target
// - New target applies only after new command
// - Failed margining retries, sets flags, alert
// - Limit commands carry two-byte direct payloads
// - Voltage scale is code over 32767
// - ADC full scale is 2.048 V
// - Current is ADC voltage over calibration gain
// - Overvoltage fault sets flags, action, alert
// - Overvoltage fault clears 2% below limit
// - Overvoltage warning sets flags, no shutdown
// - Overvoltage warning clears 2% below limit
// - Undervoltage warning sets flags and alert
// - Undervoltage warning clears 2% above limit
// - Undervoltage warning masked before power-good, off
// - Mode reads 40h, write flags comm error
// - Capability reports 400 kHz, no PEC
module rail_limit_monitor
  import rail_limit_pkg::*;
#(
  parameter int ADC_BITS = 16
) (
  input  wire logic                core_clk_in,
  input  wire logic                rst_n_in,
  input  wire cmd_req_t            cmd_req_in,
  output logic                     cmd_ack_out,
  output logic [15:0]              cmd_rdata_out,
  input  wire logic                adc_valid_in,
  input  wire logic [ADC_BITS-1:0] adc_vout_code_in,
  input  wire logic [ADC_BITS-1:0] current_sense_input_in,
  input  wire logic [15:0]         pg_on_level_in,
  input  wire logic                supply_enable_in,
  input  wire logic                margin_fail_in,
  output logic                     margin_active_out,
  output logic [15:0]              margin_target_out,
  output logic                     supply_off_out,
  output logic                     alert_n_out,
  output status_t                  status_out
);
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_DIV_V = 2'b01,
    ST_DIV_I = 2'b10,
    ST_CMP   = 2'b11
  } eval_state_t;

  localparam int DIV_W = 32;

  if (ADC_BITS < 12 || ADC_BITS > 16)
  begin : g_chk
    $error("rail_limit_monitor: ADC_BITS must be 12..16");
  end

  eval_state_t        st_r;
  logic [15:0]        margin_low_r;
  logic [15:0]        vscale_r;
  logic [15:0]        igain_r;
  logic [15:0]        ov_fault_lim_r;
  logic [15:0]        ov_warn_lim_r;
  logic [15:0]        uv_warn_lim_r;
  logic [15:0]        mode_cfg_r;
  logic [15:0]        fault_cfg_r;
  logic [31:0]        v_mv_r;
  logic [31:0]        i_mv_r;
  logic [15:0]        vout_r;
  logic [15:0]        iout_r;
  logic               ov_fault_act_r;
  logic               ov_warn_act_r;
  logic               uv_warn_act_r;
  logic               pg_seen_r;
  logic [7:0]         svout_r;
  logic               sw_ov_r;
  logic               cml_r;
  logic               margin_fault_r;
  logic               div_start;
  logic [DIV_W-1:0]   div_num;
  logic [DIV_W-1:0]   div_den;
  logic               div_done;
  logic [DIV_W-1:0]   div_quot;
  logic [15:0]        div_sat;
  logic               wr_en;
  logic               rd_en;
  logic               clr_en;
  logic               ro_wr;
  logic               known;
  logic [15:0]        rd_data;
  logic [16:0]        uv_clr_lvl;

  // Two percent of a limit, rounded down
  function automatic logic [15:0] hyst2(input logic [15:0] lim);
    logic [31:0] prod;
    prod  = {16'h0000, lim} * HYST_NUM;
    hyst2 = prod[HYST_SHIFT+15:HYST_SHIFT];
  endfunction

  assign wr_en  = cmd_req_in.valid && cmd_req_in.write;
  assign rd_en  = cmd_req_in.valid && !cmd_req_in.write;
  assign clr_en = wr_en && (cmd_req_in.code == CMD_CLEAR_FAULTS);

  // Writable configuration words
  // two-byte payloads
  always_ff @(posedge core_clk_in)
  begin
    if (!rst_n_in)
    begin
      margin_low_r   <= RST_MARGIN_LOW;
      vscale_r       <= RST_VSCALE;
      igain_r        <= RST_IGAIN;
      ov_fault_lim_r <= RST_OV_FAULT;
      ov_warn_lim_r  <= RST_OV_WARN;
      uv_warn_lim_r  <= RST_UV_WARN;
      mode_cfg_r     <= RST_MODE_CFG;
      fault_cfg_r    <= RST_FAULT_CFG;
    end
    else if (wr_en)
    begin
      case (cmd_req_in.code)
        CMD_MARGIN_LOW: margin_low_r   <= cmd_req_in.data;
        CMD_VSCALE:     vscale_r       <= cmd_req_in.data;
        CMD_IGAIN:      igain_r        <= cmd_req_in.data;
        CMD_OV_FAULT:   ov_fault_lim_r <= cmd_req_in.data;
        CMD_OV_WARN:    ov_warn_lim_r  <= cmd_req_in.data;
        CMD_UV_WARN:    uv_warn_lim_r  <= cmd_req_in.data;
        CMD_MODE_CFG:   mode_cfg_r     <= cmd_req_in.data;
        CMD_FAULT_CFG:  fault_cfg_r    <= cmd_req_in.data;
        default:        mode_cfg_r     <= mode_cfg_r;
      endcase
    end
  end

  // Margin target is copied only by the operation command, so later edits wait
  // apply low target
  always_ff @(posedge core_clk_in)
  begin
    if (!rst_n_in)
    begin
      margin_active_out <= 1'b0;
      margin_target_out <= 16'h0000;
    end
    else if (wr_en && cmd_req_in.code == CMD_OPERATION)
    begin
      if (cmd_req_in.data[OP_MARGIN_LSB+:2] == OP_MARGIN_LOW)
      begin
        margin_active_out <= 1'b1;
        margin_target_out <= margin_low_r;
      end
      else
      begin
        margin_active_out <= 1'b0;
      end
    end
  end

  // Evaluation sequencer: divide voltage, then current, then compare
  // one pass per sample
  always_ff @(posedge core_clk_in)
  begin
    if (!rst_n_in)
    begin
      st_r   <= ST_IDLE;
      v_mv_r <= 32'h0000_0000;
      i_mv_r <= 32'h0000_0000;
      vout_r <= 16'h0000;
      iout_r <= 16'h0000;
    end
    else
    begin
      case (st_r)
        ST_IDLE:
        begin
          if (adc_valid_in)
          begin
            st_r <= ST_DIV_V;
            v_mv_r <= ({{(32-ADC_BITS){1'b0}}, adc_vout_code_in} * ADC_FULL_MV) >> ADC_BITS;
            i_mv_r <= ({{(32-ADC_BITS){1'b0}}, current_sense_input_in} * ADC_FULL_MV) >> ADC_BITS;
          end
        end
        ST_DIV_V:
        begin
          if (div_done)
          begin
            vout_r <= div_sat;
            st_r   <= ST_DIV_I;
          end
        end
        ST_DIV_I:
        begin
          if (div_done)
          begin
            iout_r <= div_sat;
            st_r   <= ST_CMP;
          end
        end
        ST_CMP:  st_r <= ST_IDLE;
        default: st_r <= ST_IDLE;
      endcase
    end
  end

  // Divider operands; a sample arriving mid-pass is dropped, not queued
  // Start is held off in the done cycle, else the idle divider would relaunch on the voltage operands
  always_comb
  begin
    div_start = 1'b0;
    div_num   = v_mv_r * SCALE_UNITY;
    div_den   = {16'h0000, vscale_r};
    if (st_r == ST_DIV_V)
    begin
      div_start = !div_done;
    end
    if (st_r == ST_DIV_I)
    begin
      div_start = !div_done;
      div_num   = i_mv_r * IGAIN_MA;
      div_den   = {16'h0000, igain_r};
    end
  end

  // Results above 16 bits saturate
  assign div_sat = (div_quot[31:16] != 16'h0000) ? 16'hffff : div_quot[15:0];

  restoring_divider #(
    .W (DIV_W)
  ) u_div (
    .core_clk_in (core_clk_in),
    .rst_n_in    (rst_n_in),
    .start_in    (div_start),
    .num_in      (div_num),
    .den_in      (div_den),
    .busy_out    (),
    .done_out    (div_done),
    .quot_out    (div_quot)
  );

  assign uv_clr_lvl = {1'b0, uv_warn_lim_r} + {1'b0, hyst2(uv_warn_lim_r)};

  // Limit conditions with hysteresis, updated once per evaluated sample; supply off clears the undervoltage warning in any cycle
  always_ff @(posedge core_clk_in)
  begin
    if (!rst_n_in)
    begin
      ov_fault_act_r <= 1'b0;
      ov_warn_act_r  <= 1'b0;
      uv_warn_act_r  <= 1'b0;
      pg_seen_r      <= 1'b0;
    end
    else
    begin
      if (!supply_enable_in)
      begin
        pg_seen_r     <= 1'b0;
        uv_warn_act_r <= 1'b0;
      end
      if (st_r == ST_CMP)
      begin
        if (vout_r > ov_fault_lim_r)
          ov_fault_act_r <= 1'b1;
        else if (vout_r <= ov_fault_lim_r - hyst2(ov_fault_lim_r))
          ov_fault_act_r <= 1'b0;
        if (vout_r > ov_warn_lim_r)
          ov_warn_act_r <= 1'b1;
        else if (vout_r <= ov_warn_lim_r - hyst2(ov_warn_lim_r))
          ov_warn_act_r <= 1'b0;
        if (supply_enable_in && vout_r >= pg_on_level_in)
          pg_seen_r <= 1'b1;
        if (supply_enable_in && pg_seen_r)
        begin
          if (vout_r < uv_warn_lim_r)
            uv_warn_act_r <= 1'b1;
          else if ({1'b0, vout_r} >= uv_clr_lvl)
            uv_warn_act_r <= 1'b0;
        end
      end
    end
  end

  // Latched status; a live condition wins over a clear in the same cycle
  always_ff @(posedge core_clk_in)
  begin
    if (!rst_n_in)
    begin
      svout_r <= 8'h00;
      sw_ov_r <= 1'b0;
    end
    else
    begin
      svout_r[SV_OV_FAULT] <= ov_fault_act_r | (svout_r[SV_OV_FAULT] & ~clr_en);
      svout_r[SV_OV_WARN]  <= ov_warn_act_r | (svout_r[SV_OV_WARN] & ~clr_en);
      svout_r[SV_UV_WARN]  <= uv_warn_act_r | (svout_r[SV_UV_WARN] & ~clr_en);
      sw_ov_r              <= ov_fault_act_r | (sw_ov_r & ~clr_en);
    end
  end

  // Margin failure stays flagged while the loop keeps retrying
  // margin failure flags
  always_ff @(posedge core_clk_in)
  begin
    if (!rst_n_in)
      margin_fault_r <= 1'b0;
    else
      margin_fault_r <= margin_fail_in | (margin_fault_r & ~clr_en);
  end

  // Fault action: shutdown only from the fault, never from warnings
  // configured fault action
  always_ff @(posedge core_clk_in)
  begin
    if (!rst_n_in)
      supply_off_out <= 1'b0;
    else if (ov_fault_act_r && fault_cfg_r[FAULT_SHUTDOWN_EN])
      supply_off_out <= 1'b1;
    else if (clr_en)
      supply_off_out <= 1'b0;
  end

  // Status carrier built in one process so the struct keeps a single driver
  always_comb
  begin
    status_out.vout             = svout_r;
    status_out.mfr              = {7'h00, margin_fault_r};
    status_out.word             = 16'h0000;
    status_out.word[SW_VOUT]    = |svout_r;
    status_out.word[SW_MARGIN]  = margin_fault_r;
    status_out.word[SW_VOUT_OV] = sw_ov_r;
    status_out.word[SW_CML]     = cml_r;
  end

  // Alert is registered so it cannot glitch on the open-drain pin
  // alert when enabled
  always_ff @(posedge core_clk_in)
  begin
    if (!rst_n_in)
      alert_n_out <= 1'b1;
    else
      alert_n_out <= ~(mode_cfg_r[MODE_ALERT_EN] && (|svout_r || sw_ov_r || margin_fault_r || cml_r));
  end

  // Read decode
  always_comb
  begin
    known   = 1'b1;
    rd_data = 16'h0000;
    case (cmd_req_in.code)
      CMD_CAPABILITY:  rd_data = {8'h00, CAP_BASE | (8'(mode_cfg_r[MODE_ALERT_EN]) << CAP_ALERT_BIT)};
      CMD_VOUT_MODE:   rd_data = {8'h00, VOUT_MODE_DIRECT};
      CMD_MARGIN_LOW:  rd_data = margin_low_r;
      CMD_VSCALE:      rd_data = vscale_r;
      CMD_IGAIN:       rd_data = igain_r;
      CMD_OV_FAULT:    rd_data = ov_fault_lim_r;
      CMD_OV_WARN:     rd_data = ov_warn_lim_r;
      CMD_UV_WARN:     rd_data = uv_warn_lim_r;
      CMD_MODE_CFG:    rd_data = mode_cfg_r;
      CMD_FAULT_CFG:   rd_data = fault_cfg_r;
      CMD_STATUS_WORD: rd_data = status_out.word;
      CMD_STATUS_VOUT: rd_data = {8'h00, svout_r};
      CMD_STATUS_MFR:  rd_data = {8'h00, status_out.mfr};
      CMD_READ_VOUT:   rd_data = vout_r;
      CMD_READ_IOUT:   rd_data = iout_r;
      CMD_OPERATION:   rd_data = 16'h0000;
      CMD_CLEAR_FAULTS: rd_data = 16'h0000;
      default:         known   = 1'b0;
    endcase
  end

  assign ro_wr = (cmd_req_in.code == CMD_CAPABILITY) || (cmd_req_in.code == CMD_VOUT_MODE) ||
                 (cmd_req_in.code == CMD_STATUS_WORD) || (cmd_req_in.code == CMD_STATUS_VOUT) ||
                 (cmd_req_in.code == CMD_STATUS_MFR) || (cmd_req_in.code == CMD_READ_VOUT) ||
                 (cmd_req_in.code == CMD_READ_IOUT);

  // Answer one cycle after each request
  // capability answer
  always_ff @(posedge core_clk_in)
  begin
    if (!rst_n_in)
    begin
      cmd_ack_out   <= 1'b0;
      cmd_rdata_out <= 16'h0000;
    end
    else
    begin
      cmd_ack_out <= cmd_req_in.valid;
      if (rd_en)
        cmd_rdata_out <= rd_data;
    end
  end

  // Communication error on read-only writes and unknown codes
  // mode write error
  always_ff @(posedge core_clk_in)
  begin
    if (!rst_n_in)
      cml_r <= 1'b0;
    else if (cmd_req_in.valid && (!known || (wr_en && ro_wr)))
      cml_r <= 1'b1;
    else if (clr_en)
      cml_r <= 1'b0;
  end

  sequence s_sample;
    st_r == ST_IDLE && adc_valid_in;
  endsequence

  sequence s_ov_seen;
    st_r == ST_CMP && vout_r > ov_fault_lim_r;
  endsequence

  a_margin_apply: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    wr_en && cmd_req_in.code == CMD_OPERATION && cmd_req_in.data[OP_MARGIN_LSB+:2] == OP_MARGIN_LOW
    |=> margin_active_out && margin_target_out == $past(margin_low_r))
    else $error("margin target not applied");

  a_margin_hold: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    margin_active_out && wr_en && cmd_req_in.code == CMD_MARGIN_LOW |=> $stable(margin_target_out))
    else $error("margin target moved on value write");

  a_margin_flag: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    margin_fail_in |=> status_out.word[SW_MARGIN] && status_out.mfr[SM_MARGIN_FAULT])
    else $error("margin failure not flagged");

  a_eval_pass: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    s_sample |-> ##[66:70] st_r == ST_CMP)
    else $error("sample not evaluated in time");

  a_ov_set: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    s_ov_seen |-> ##2 status_out.vout[SV_OV_FAULT] && status_out.word[SW_VOUT] && status_out.word[SW_VOUT_OV])
    else $error("overvoltage fault not flagged");

  a_ov_hold: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    st_r == ST_CMP && ov_fault_act_r && vout_r > ov_fault_lim_r - hyst2(ov_fault_lim_r) |=> ov_fault_act_r)
    else $error("overvoltage fault cleared inside band");

  a_warn_noact: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    $rose(supply_off_out) |-> $past(ov_fault_act_r))
    else $error("shutdown without fault");

  a_uv_mask: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    !supply_enable_in |=> !uv_warn_act_r && !pg_seen_r)
    else $error("undervoltage warning not masked");

  a_uv_hold: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    st_r == ST_CMP && uv_warn_act_r && supply_enable_in && {1'b0, vout_r} < uv_clr_lvl |=> uv_warn_act_r)
    else $error("undervoltage warning cleared inside band");

  a_mode_read: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    rd_en && cmd_req_in.code == CMD_VOUT_MODE |=> cmd_ack_out && cmd_rdata_out == 16'h0040)
    else $error("mode read wrong");

  a_mode_write: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    wr_en && cmd_req_in.code == CMD_VOUT_MODE |=> status_out.word[SW_CML])
    else $error("mode write not flagged");

  a_cap_read: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    rd_en && cmd_req_in.code == CMD_CAPABILITY |=> cmd_rdata_out[7:5] == 3'h1)
    else $error("capability wrong");
endmodule // rail_limit_monitor

// ---- hdl/restoring_divider.sv ----
// Sequential restoring divider, one quotient bit per clock
`timescale 1ns/10ps
module restoring_divider #(
  parameter int W = 32
) (
  input  wire logic         core_clk_in,
  input  wire logic         rst_n_in,
  input  wire logic         start_in,
  input  wire logic [W-1:0] num_in,
  input  wire logic [W-1:0] den_in,
  output logic              busy_out,
  output logic              done_out,
  output logic [W-1:0]      quot_out
);
  logic [W-1:0]         rem_r;
  logic [W-1:0]         den_r;
  logic [7:0]           cnt_r;
  logic [W:0]           shl;
  logic [W:0]           diff;

  if (W < 2 || W > 255)
  begin : g_chk
    $error("restoring_divider: W out of range");
  end

  // A zero divisor yields all ones, which callers treat as saturation
  assign shl  = {rem_r, quot_out[W-1]};
  assign diff = shl - {1'b0, den_r};

  // Iteration
  always_ff @(posedge core_clk_in)
  begin
    if (!rst_n_in)
    begin
      rem_r    <= '0;
      den_r    <= '0;
      cnt_r    <= 8'h00;
      quot_out <= '0;
      busy_out <= 1'b0;
      done_out <= 1'b0;
    end
    else
    begin
      done_out <= 1'b0;
      if (start_in && !busy_out)
      begin
        busy_out <= 1'b1;
        rem_r    <= '0;
        quot_out <= num_in;
        den_r    <= den_in;
        cnt_r    <= 8'(W);
      end
      else if (busy_out)
      begin
        rem_r    <= diff[W] ? shl[W-1:0] : diff[W-1:0];
        quot_out <= {quot_out[W-2:0], ~diff[W]};
        cnt_r    <= cnt_r - 8'h01;
        if (cnt_r == 8'h01)
        begin
          busy_out <= 1'b0;
          done_out <= 1'b1;
        end
      end
    end
  end
endmodule // restoring_divider

// ---- include/rail_limit_pkg.sv ----
// Shared command codes, field positions, reset values and carrier types for the rail limit monitor
package rail_limit_pkg;
  // Command codes of the command layer
  localparam logic [7:0] CMD_OPERATION    = 8'h01;
  localparam logic [7:0] CMD_CLEAR_FAULTS = 8'h03;
  localparam logic [7:0] CMD_CAPABILITY   = 8'h19;
  localparam logic [7:0] CMD_VOUT_MODE    = 8'h20;
  localparam logic [7:0] CMD_MARGIN_LOW   = 8'h26;
  localparam logic [7:0] CMD_VSCALE       = 8'h2a;
  localparam logic [7:0] CMD_IGAIN        = 8'h38;
  localparam logic [7:0] CMD_OV_FAULT     = 8'h40;
  localparam logic [7:0] CMD_OV_WARN      = 8'h42;
  localparam logic [7:0] CMD_UV_WARN      = 8'h43;
  localparam logic [7:0] CMD_STATUS_WORD  = 8'h79;
  localparam logic [7:0] CMD_STATUS_VOUT  = 8'h7a;
  localparam logic [7:0] CMD_STATUS_MFR   = 8'h80;
  localparam logic [7:0] CMD_READ_VOUT    = 8'h8b;
  localparam logic [7:0] CMD_READ_IOUT    = 8'h8c;
  localparam logic [7:0] CMD_MODE_CFG     = 8'hd1;
  localparam logic [7:0] CMD_FAULT_CFG    = 8'hd5;
  // Fixed read answers
  localparam logic [7:0] VOUT_MODE_DIRECT = 8'h40;
  localparam logic [7:0] CAP_BASE         = 8'h20;
  localparam int         CAP_ALERT_BIT    = 4;
  // Operation command margin field
  localparam int         OP_MARGIN_LSB    = 4;
  localparam logic [1:0] OP_MARGIN_LOW    = 2'h1;
  // Status word bits
  localparam int SW_VOUT    = 15;
  localparam int SW_MARGIN  = 9;
  localparam int SW_VOUT_OV = 5;
  localparam int SW_CML     = 1;
  // Status vout bits
  localparam int SV_OV_FAULT = 7;
  localparam int SV_OV_WARN  = 6;
  localparam int SV_UV_WARN  = 5;
  // Status mfr bits and configuration bits
  localparam int SM_MARGIN_FAULT   = 0;
  localparam int MODE_ALERT_EN     = 0;
  localparam int FAULT_SHUTDOWN_EN = 0;
  // Reset values
  localparam logic [15:0] RST_MARGIN_LOW = 16'h0000;
  localparam logic [15:0] RST_VSCALE     = 16'h7fff;
  localparam logic [15:0] RST_IGAIN      = 16'h0001;
  localparam logic [15:0] RST_OV_FAULT   = 16'hffff;
  localparam logic [15:0] RST_OV_WARN    = 16'hffff;
  localparam logic [15:0] RST_UV_WARN    = 16'h0000;
  localparam logic [15:0] RST_MODE_CFG   = 16'h0001;
  localparam logic [15:0] RST_FAULT_CFG  = 16'h0001;
  // Conversion constants: mV full scale, unity scale code, mV/0.1mohm to mA
  localparam logic [31:0] ADC_FULL_MV = 32'h0000_0800;
  localparam logic [31:0] SCALE_UNITY = 32'h0000_7fff;
  localparam logic [31:0] IGAIN_MA    = 32'h0000_2710;
  // Two percent as a fraction of 2^16
  localparam logic [31:0] HYST_NUM    = 32'h0000_051f;
  localparam int          HYST_SHIFT  = 16;

  typedef struct packed {
    logic        valid;
    logic        write;
    logic [7:0]  code;
    logic [15:0] data;
  } cmd_req_t;

  typedef struct packed {
    logic [15:0] word;
    logic [7:0]  vout;
    logic [7:0]  mfr;
  } status_t;
endpackage

// ---- verification/rail_supply_model.sv ----
// Monitored supply model: turns a rail voltage into one paired sample strobe
`timescale 1ns/10ps
module rail_supply_model #(
  parameter int ADC_BITS = 16
) (
  input  wire logic                core_clk_in,
  input  wire logic                take_in,
  input  wire logic [15:0]         rail_mv_in,
  output logic                     adc_valid_out,
  output logic [ADC_BITS-1:0]      vcode_out,
  output logic [ADC_BITS-1:0]      icode_out
);
  initial
  begin
    adc_valid_out = 1'b0;
    vcode_out     = '0;
    icode_out     = '0;
  end
  // Rails stay under 1.8 V, limits kept in order
  // Codes outside a strobe toggle so stale values never look valid
  always @(negedge core_clk_in)
  begin
    adc_valid_out <= take_in;
    if (take_in)
    begin
      vcode_out <= ADC_BITS'((32'(rail_mv_in) << ADC_BITS) >> 11);
      icode_out <= ADC_BITS'((32'(rail_mv_in) << ADC_BITS) >> 12); // Half the rail, so both paths differ
    end
    else
    begin
      vcode_out <= ~vcode_out;
      icode_out <= ~icode_out;
    end
  end
endmodule // rail_supply_model

// ---- verification/tb_rail_limit_monitor.sv ----
// Self-checking bench for the rail limit monitor
`timescale 1ns/10ps
module tb_rail_limit_monitor
  import rail_limit_pkg::*;
;
  logic        core_clk_in = 1'b0;
  logic        rst_n_in    = 1'b0;
  cmd_req_t    req         = '0;
  logic        take        = 1'b0;
  logic [15:0] rail_mv     = 16'h0000;
  logic [15:0] pg_on       = 16'h0000;
  logic        sup_en      = 1'b0;
  logic        m_fail      = 1'b0;
  logic        adc_valid, ack, m_act, sup_off, alert_n;
  logic [15:0] vcode, icode, rdata, m_tgt, r1, r2;
  status_t     st;
  logic [16:0] exp_q[$];
  logic [16:0] note;
  logic [31:0] seed = 32'h0001_3bd2;
  int          n_errors = 0;
  int          samples_checked = 0;
  int          cyc = 0;
  logic [7:0]  codes[6] = '{CMD_MARGIN_LOW, CMD_VSCALE, CMD_IGAIN, CMD_OV_FAULT, CMD_OV_WARN, CMD_UV_WARN};
  logic [15:0] rsts[6]  = '{RST_MARGIN_LOW, RST_VSCALE, RST_IGAIN, RST_OV_FAULT, RST_OV_WARN, RST_UV_WARN};
  logic [15:0] mv[9]    = '{16'h044c, 16'h03de, 16'h03ca, 16'h0190, 16'h0190, 16'h0352, 16'h0190, 16'h01f9, 16'h0203};
  logic [7:0]  ev[9]    = '{8'hc0, 8'hc0, 8'h40, 8'h00, 8'h00, 8'h00, 8'h20, 8'h20, 8'h00};

  always #12.5 core_clk_in = ~core_clk_in;

  rail_limit_monitor u_rail_limit_monitor (.core_clk_in(core_clk_in), .rst_n_in(rst_n_in), .cmd_req_in(req),
    .cmd_ack_out(ack), .cmd_rdata_out(rdata), .adc_valid_in(adc_valid), .adc_vout_code_in(vcode),
    .current_sense_input_in(icode), .pg_on_level_in(pg_on), .supply_enable_in(sup_en), .margin_fail_in(m_fail),
    .margin_active_out(m_act), .margin_target_out(m_tgt), .supply_off_out(sup_off), .alert_n_out(alert_n),
    .status_out(st));
  rail_supply_model u_rail_supply_model (.core_clk_in(core_clk_in), .take_in(take), .rail_mv_in(rail_mv),
    .adc_valid_out(adc_valid), .vcode_out(vcode), .icode_out(icode));

  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction

  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("FAIL %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic close_out();
    if (n_errors == 0 && samples_checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // One command, its expected read answer noted for the watcher
  task automatic cmd(input logic w, input logic [7:0] c, input logic [15:0] d, input logic on, input logic [15:0] e);
    @(negedge core_clk_in);
    req <= '{1'b1, w, c, d};
    exp_q.push_back({on, e});
    @(negedge core_clk_in);
    req.valid <= 1'b0;
  endtask

  // Sample strobe, then wait out the fixed evaluation pass
  task automatic sample(input logic [15:0] v);
    @(negedge core_clk_in);
    rail_mv <= v;
    take    <= 1'b1;
    @(negedge core_clk_in);
    take <= 1'b0;
    repeat (80) @(negedge core_clk_in);
  endtask

  // Watcher: each acknowledge retires the oldest note
  always @(negedge core_clk_in)
  begin
    if (ack === 1'b1)
    begin
      note = exp_q.pop_front();
      if (note[16]) chk("rdata", rdata, note[15:0]);
    end
  end

  // Hang guard, far above the roughly 950 cycles of the run
  always @(posedge core_clk_in)
  begin
    cyc++;
    if (cyc == 8000)
    begin
      n_errors++;
      close_out();
    end
  end

  initial
  begin
    repeat (10) @(negedge core_clk_in);
    rst_n_in <= 1'b1;
    for (int i = 0; i < 6; i++)
    begin
      seed = xs(seed);
      cmd(1'b0, codes[i], '0, 1'b1, rsts[i]);
      cmd(1'b1, codes[i], seed[15:0], 1'b0, '0);
      cmd(1'b0, codes[i], '0, 1'b1, seed[15:0]);
    end
    // Fixed answers; write to read-only flags comm error
    cmd(1'b0, CMD_VOUT_MODE, '0, 1'b1, 16'h0040);
    cmd(1'b0, CMD_CAPABILITY, '0, 1'b1, 16'h0030);
    cmd(1'b1, CMD_MODE_CFG, 16'h0000, 1'b0, '0);
    cmd(1'b0, CMD_CAPABILITY, '0, 1'b1, 16'h0020);
    cmd(1'b1, CMD_MODE_CFG, 16'h0001, 1'b0, '0);
    cmd(1'b1, CMD_VOUT_MODE, 16'h0055, 1'b0, '0);
    cmd(1'b0, CMD_STATUS_WORD, '0, 1'b1, 16'h0002);
    cmd(1'b1, CMD_VSCALE, 16'h7fff, 1'b0, '0);
    cmd(1'b1, CMD_IGAIN, 16'h2710, 1'b0, '0);
    cmd(1'b1, CMD_OV_FAULT, 16'h03e8, 1'b0, '0);
    cmd(1'b1, CMD_OV_WARN, 16'h0384, 1'b0, '0);
    cmd(1'b1, CMD_UV_WARN, 16'h01f4, 1'b0, '0);
    pg_on <= 16'h0320;
    // to Limit table with hysteresis edges and masking
    for (int i = 0; i < 9; i++)
    begin
      sup_en <= (i > 3);
      sample(mv[i]);
      cmd(1'b0, CMD_READ_VOUT, '0, 1'b1, mv[i]);
      cmd(1'b0, CMD_READ_IOUT, '0, 1'b1, mv[i] >> 1);
      cmd(1'b1, CMD_CLEAR_FAULTS, '0, 1'b0, '0);
      cmd(1'b0, CMD_STATUS_VOUT, '0, 1'b1, {8'h00, ev[i]});
      cmd(1'b0, CMD_STATUS_WORD, '0, 1'b1, {|ev[i], 9'h000, ev[i][7], 5'h00});
      repeat (3) @(negedge core_clk_in);
      chk("alert_n", 16'(alert_n), 16'(ev[i] == 8'h00));
      chk("supply_off", 16'(sup_off), 16'(ev[i][7]));
      chk("status_vout", {8'h00, st.vout}, {8'h00, ev[i]});
    end
    // Margin target held until reissued; failure flags
    seed = xs(seed);
    r1 = seed[15:0];
    seed = xs(seed);
    r2 = seed[15:0];
    cmd(1'b1, CMD_MARGIN_LOW, r1, 1'b0, '0);
    cmd(1'b1, CMD_OPERATION, 16'h0010, 1'b0, '0);
    cmd(1'b1, CMD_MARGIN_LOW, r2, 1'b0, '0);
    chk("margin_active", 16'(m_act), 16'h0001);
    chk("margin_target", m_tgt, r1);
    cmd(1'b1, CMD_OPERATION, 16'h0010, 1'b0, '0);
    chk("margin_target", m_tgt, r2);
    cmd(1'b1, CMD_OPERATION, 16'h0000, 1'b0, '0);
    chk("margin_active", 16'(m_act), 16'h0000);
    m_fail <= 1'b1;
    cmd(1'b0, CMD_STATUS_WORD, '0, 1'b1, 16'h0200);
    cmd(1'b0, CMD_STATUS_MFR, '0, 1'b1, 16'h0001);
    repeat (3) @(negedge core_clk_in);
    chk("alert_n", 16'(alert_n), 16'h0000);
    close_out();
  end
endmodule // tb_rail_limit_monitor
